// file: rtl/qpio_defines.svh
/*
  constants for the quad port block: register offsets, field positions,
  reset values. assumes inclusion once per compile unit by bare name.
*/
`ifndef QPIO_DEFINES_SVH
`define QPIO_DEFINES_SVH

// register byte offsets
`define QPIO_OFF_P0DATA   12'h000
`define QPIO_OFF_P1DATA   12'h004
`define QPIO_OFF_P2DATA   12'h008
`define QPIO_OFF_P3DATA   12'h00C
`define QPIO_OFF_P01MODE  12'h010
`define QPIO_OFF_P2DIR    12'h014
`define QPIO_OFF_P3MODE   12'h018
`define QPIO_OFF_STATUS   12'h01C
`define QPIO_OFF_BUSADDR  12'h020
`define QPIO_OFF_PINS     12'h024

// port 0/1 mode fields
`define QPIO_P01_P0LO_ADDR 0
`define QPIO_P01_P0HI_ADDR 1
`define QPIO_P01_P0LO_OUT  2
`define QPIO_P01_P0HI_OUT  3
`define QPIO_P01_P1_ADDR   4
`define QPIO_P01_P1_OUT    5
`define QPIO_P01_FLOAT     6

// port 3 mode fields
`define QPIO_P3_HS0      0
`define QPIO_P3_HS1      1
`define QPIO_P3_HS2      2
`define QPIO_P3_SERIAL   3
`define QPIO_P3_BUSREQ   4
`define QPIO_P3_DSEL     5
`define QPIO_P3_TOUT_LO  6
`define QPIO_P3_TOUT_HI  7
`define QPIO_P3_OPENDR   8

// reset values: ports zero to two inputs, specials off
`define QPIO_RST_P01MODE  8'h00
`define QPIO_RST_P2DIR    8'hFF
`define QPIO_RST_P3MODE   9'h000

// address thresholds
`define QPIO_INT_LIMIT    16'h0800
`define QPIO_PAGE_LIMIT   16'h0100

`endif

// file: rtl/qpio_pkg.sv
/*
  types for the quad port block.
  assumes qpio_defines.svh supplies the numbers.
*/
`default_nettype none
package qpio_pkg;
    // handshake engine state
    typedef enum logic [1:0] {
        QPIO_HS_IDLE = 2'b00,
        QPIO_HS_SENT = 2'b01,
        QPIO_HS_DONE = 2'b10
    } qpio_hs_type;

    // timer output source select
    typedef enum logic [1:0] {
        QPIO_TOUT_OFF  = 2'b00,
        QPIO_TOUT_T0   = 2'b01,
        QPIO_TOUT_T1   = 2'b10,
        QPIO_TOUT_CLK  = 2'b11
    } qpio_tout_type;

    // one eight-bit port at the pads
    typedef struct packed {
        logic [7:0] dataOut;
        logic [7:0] outEnable_n;
    } qpio_pad_type;

    // external memory bus request
    typedef struct packed {
        logic        start;
        logic        write;
        logic        dataSpace;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } qpio_mem_type;
endpackage
`default_nettype wire

// file: rtl/qpio_ports.sv
/*
  four eight-bit port units with handshake, address/data bus, and
  port three special lines, registers reached over apb.
  assumes one clock, synchronous active-high reset, pins from outside
  the clock domain, timer sources from same-clock logic.
*/
// Chosen here: the address map and the APB slave port.
`include "qpio_defines.svh"
`default_nettype none
//
// Behaviour
// - four eight-bit ports, each configurable
// - port one is I/O or address/data
// - port one handshake on lines 3 and 4
// - addresses of 2048 and above go via port one
// - port zero gives high address bits
// - port one floats with strobes, read/write
// - port zero nibbles: I/O or address
// - port zero handshake on lines 2, 5
// - port zero gives A8-A11 or A8-A15
// - upper nibble stays I/O with 12 bits
// - address nibbles float with bus
// - port two per-bit direction, open-drain option
// - port two handshake follows bit 7
// - port three: 0-3 inputs, 4-7 outputs
// - serial in line 0, out line 7
// - port three carries interrupts, timer, select
// - bus acknowledge in, request out
// - line 6 outputs timer or clock
// - line 4 gives data space select
module qpio_ports
(
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 clockEnable,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // port pads, enables low while driving
    input  wire logic [31:0]          padIn,
    output qpio_pkg::qpio_pad_type    pad0,
    output qpio_pkg::qpio_pad_type    pad1,
    output qpio_pkg::qpio_pad_type    pad2,
    output qpio_pkg::qpio_pad_type    pad3,
    // bus strobes
    output logic                      address_strobe_n,
    output logic                      data_strobe_n,
    output logic                      readWrite,
    output logic                      strobeEnable_n,
    // internal sources and sinks
    input  wire logic                 serialTx,
    input  wire logic                 timer0Out,
    input  wire logic                 timer1Out,
    input  wire qpio_pkg::qpio_mem_type memReq,
    output logic                      memDone,
    output logic      [7:0]           memRdata,
    output logic      [3:0]           external_interrupt_lines,
    output logic                      serialRx,
    output logic                      busGranted
);

    // synchronised pins
    logic [31:0] padMeta_ff;
    logic [31:0] padSync_ff;

    // configuration registers
    logic [7:0]  p01Mode_ff,  nxt_p01Mode;
    logic [7:0]  p2Dir_ff,    nxt_p2Dir;
    logic [8:0]  p3Mode_ff,   nxt_p3Mode;
    logic [7:0]  outLatch_ff [4];
    logic [7:0]  nxt_outLatch [4];
    // handshake per port
    qpio_pkg::qpio_hs_type hsState_ff [3];
    qpio_pkg::qpio_hs_type nxt_hsState [3];
    logic [7:0]  hsCapture_ff [3];
    logic [7:0]  nxt_hsCapture [3];
    // bus cycle
    logic [2:0]  busPhase_ff, nxt_busPhase;
    logic [15:0] busAddr_ff,  nxt_busAddr;
    logic [7:0]  busData_ff,  nxt_busData;
    logic        busWr_ff,    nxt_busWr;
    logic        busDsel_ff,  nxt_busDsel;
    logic [7:0]  memRdata_ff, nxt_memRdata;
    logic [31:0] prdata_ff,   nxt_prdata;

    // decoded mode bits
    logic p0LoAddr, p0HiAddr, p1Addr, busFloat;
    logic [2:0] hsEn;
    logic [2:0] hsIsOut;
    logic [7:0] p0Data, p1Data, p2Data;
    logic [7:0] hsValidIn;

    // true when a bus address needs the external interface
    function automatic logic isExternal(input logic [15:0] a);
        isExternal = (a >= `QPIO_INT_LIMIT);
    endfunction

    // two-flop pin synchroniser for all 32 port lines
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            padMeta_ff <= 32'h0000_0000;
            padSync_ff <= 32'h0000_0000;
        end
        else if (clockEnable)
        begin
            padMeta_ff <= padIn;
            padSync_ff <= padMeta_ff;
        end
    end

    // mode decode
    assign p0LoAddr = p01Mode_ff[`QPIO_P01_P0LO_ADDR];
    assign p0HiAddr = p01Mode_ff[`QPIO_P01_P0HI_ADDR];
    assign p1Addr   = p01Mode_ff[`QPIO_P01_P1_ADDR];
    assign busFloat = p01Mode_ff[`QPIO_P01_FLOAT];
    assign hsEn     = p3Mode_ff[2:0];
    // direction picks which line is valid and which is ready
    assign hsIsOut[0] = p01Mode_ff[`QPIO_P01_P0HI_OUT];
    assign hsIsOut[1] = p01Mode_ff[`QPIO_P01_P1_OUT];
    assign hsIsOut[2] = ~p2Dir_ff[7];
    // input handshake lines by port: valid/ready from pins 2,3,1
    assign hsValidIn = padSync_ff[31:24];
    assign p0Data = padSync_ff[7:0];
    assign p1Data = padSync_ff[15:8];
    assign p2Data = padSync_ff[23:16];

    // handshake engines; sender holds valid, receiver drops ready
    always_comb
    begin
        logic inLine;
        inLine = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            nxt_hsState[i]   = hsState_ff[i];
            nxt_hsCapture[i] = hsCapture_ff[i];
            // port 0 uses line 2, port 1 line 3, port 2 line 1
            inLine = (i == 0) ? hsValidIn[2] : (i == 1) ? hsValidIn[3] : hsValidIn[1];
            case (hsState_ff[i])
                qpio_pkg::QPIO_HS_IDLE:
                begin
                    // input: valid_n low means data present; output: ready high
                    if (hsEn[i] && !hsIsOut[i] && !inLine)
                    begin
                        nxt_hsCapture[i] = (i == 0) ? p0Data : (i == 1) ? p1Data : p2Data;
                        nxt_hsState[i]   = qpio_pkg::QPIO_HS_DONE;
                    end
                    else if (hsEn[i] && hsIsOut[i] && inLine)
                        nxt_hsState[i] = qpio_pkg::QPIO_HS_SENT;
                end
                qpio_pkg::QPIO_HS_SENT:
                    if (!inLine)
                        nxt_hsState[i] = qpio_pkg::QPIO_HS_DONE;
                qpio_pkg::QPIO_HS_DONE:
                    if (hsIsOut[i] ? !inLine : inLine)
                        nxt_hsState[i] = qpio_pkg::QPIO_HS_IDLE;
                default:
                    nxt_hsState[i] = qpio_pkg::QPIO_HS_IDLE;
            endcase
            if (!hsEn[i])
                nxt_hsState[i] = qpio_pkg::QPIO_HS_IDLE;
        end
    end

    // external bus cycle: address, strobe, data, finish
    always_comb
    begin
        nxt_busPhase = busPhase_ff;
        nxt_busAddr  = busAddr_ff;
        nxt_busData  = busData_ff;
        nxt_busWr    = busWr_ff;
        nxt_busDsel  = busDsel_ff;
        nxt_memRdata = memRdata_ff;
        case (busPhase_ff)
            3'h0:
                if (memReq.start && p1Addr && !busFloat && isExternal(memReq.addr))
                begin
                    nxt_busAddr  = memReq.addr;
                    nxt_busData  = memReq.wdata;
                    nxt_busWr    = memReq.write;
                    nxt_busDsel  = memReq.dataSpace;
                    nxt_busPhase = 3'h1;
                end
            3'h1: nxt_busPhase = 3'h2;
            3'h2: nxt_busPhase = 3'h3;
            3'h3: nxt_busPhase = 3'h4;
            // pins lag two flops, so data seen under the strobe shows here
            3'h4:
            begin
                nxt_memRdata = p1Data;
                nxt_busPhase = 3'h5;
            end
            default: nxt_busPhase = 3'h0;
        endcase
    end

    // register writes over apb, synchronous reset values
    always_comb
    begin
        nxt_p01Mode = p01Mode_ff;
        nxt_p2Dir   = p2Dir_ff;
        nxt_p3Mode  = p3Mode_ff;
        for (int i = 0; i < 4; i++)
            nxt_outLatch[i] = outLatch_ff[i];
        nxt_prdata = prdata_ff;
        if (psel && penable && pwrite)
        begin
            if (paddr == `QPIO_OFF_P0DATA)
                nxt_outLatch[0] = pwdata[7:0];
            else if (paddr == `QPIO_OFF_P1DATA)
                nxt_outLatch[1] = pwdata[7:0];
            else if (paddr == `QPIO_OFF_P2DATA)
                nxt_outLatch[2] = pwdata[7:0];
            else if (paddr == `QPIO_OFF_P3DATA)
                nxt_outLatch[3] = pwdata[7:0];
            else if (paddr == `QPIO_OFF_P01MODE)
                nxt_p01Mode = pwdata[7:0];
            else if (paddr == `QPIO_OFF_P2DIR)
                nxt_p2Dir = pwdata[7:0];
            else if (paddr == `QPIO_OFF_P3MODE)
                nxt_p3Mode = pwdata[8:0];
        end
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == `QPIO_OFF_P0DATA)
                nxt_prdata = {24'h000000, p0Data};
            else if (paddr == `QPIO_OFF_P1DATA)
                nxt_prdata = {24'h000000, p1Data};
            else if (paddr == `QPIO_OFF_P2DATA)
                nxt_prdata = {24'h000000, p2Data};
            else if (paddr == `QPIO_OFF_P3DATA)
                nxt_prdata = {24'h000000, padSync_ff[31:24]};
            else if (paddr == `QPIO_OFF_P01MODE)
                nxt_prdata = {24'h000000, p01Mode_ff};
            else if (paddr == `QPIO_OFF_P2DIR)
                nxt_prdata = {24'h000000, p2Dir_ff};
            else if (paddr == `QPIO_OFF_P3MODE)
                nxt_prdata = {23'h000000, p3Mode_ff};
            else if (paddr == `QPIO_OFF_STATUS)
                nxt_prdata = {19'h00000, busPhase_ff, hsState_ff[2], hsState_ff[1],
                              hsState_ff[0], 3'h0, busGranted};
            else if (paddr == `QPIO_OFF_BUSADDR)
                nxt_prdata = {16'h0000, busAddr_ff};
            else if (paddr == `QPIO_OFF_PINS)
                nxt_prdata = {hsCapture_ff[2], hsCapture_ff[1], hsCapture_ff[0], memRdata_ff};
            else
                nxt_prdata = 32'h0000_0000;
        end
    end

    // state registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            p01Mode_ff  <= `QPIO_RST_P01MODE;
            p2Dir_ff    <= `QPIO_RST_P2DIR;
            p3Mode_ff   <= `QPIO_RST_P3MODE;
            for (int i = 0; i < 4; i++)
                outLatch_ff[i] <= 8'h00;
            for (int i = 0; i < 3; i++)
            begin
                hsState_ff[i]   <= qpio_pkg::QPIO_HS_IDLE;
                hsCapture_ff[i] <= 8'h00;
            end
            busPhase_ff <= 3'h0;
            busAddr_ff  <= 16'h0000;
            busData_ff  <= 8'h00;
            busWr_ff    <= 1'b0;
            busDsel_ff  <= 1'b0;
            memRdata_ff <= 8'h00;
            prdata_ff   <= 32'h0000_0000;
        end
        else if (clockEnable)
        begin
            p01Mode_ff  <= nxt_p01Mode;
            p2Dir_ff    <= nxt_p2Dir;
            p3Mode_ff   <= nxt_p3Mode;
            for (int i = 0; i < 4; i++)
                outLatch_ff[i] <= nxt_outLatch[i];
            for (int i = 0; i < 3; i++)
            begin
                hsState_ff[i]   <= nxt_hsState[i];
                hsCapture_ff[i] <= nxt_hsCapture[i];
            end
            busPhase_ff <= nxt_busPhase;
            busAddr_ff  <= nxt_busAddr;
            busData_ff  <= nxt_busData;
            busWr_ff    <= nxt_busWr;
            busDsel_ff  <= nxt_busDsel;
            memRdata_ff <= nxt_memRdata;
            prdata_ff   <= nxt_prdata;
        end
    end

    // apb answer: no wait states, data from flop
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_ff;
    assign memDone = (busPhase_ff == 3'h5);
    assign memRdata = memRdata_ff;

    // port zero pads: lower nibble A8-A11, upper A12-A15 or I/O
    always_comb
    begin
        pad0.dataOut[3:0]     = p0LoAddr ? busAddr_ff[11:8] : outLatch_ff[0][3:0];
        pad0.dataOut[7:4]     = p0HiAddr ? busAddr_ff[15:12] : outLatch_ff[0][7:4];
        pad0.outEnable_n[3:0] = p0LoAddr ? {4{busFloat}}
                              : {4{~p01Mode_ff[`QPIO_P01_P0LO_OUT]}};
        pad0.outEnable_n[7:4] = p0HiAddr ? {4{busFloat}}
                              : {4{~p01Mode_ff[`QPIO_P01_P0HI_OUT]}};
    end

    // port one pads: multiplexed address then data
    always_comb
    begin
        if (p1Addr)
        begin
            pad1.dataOut     = (busPhase_ff == 3'h1) ? busAddr_ff[7:0] : busData_ff;
            pad1.outEnable_n = {8{busFloat || !((busPhase_ff == 3'h1)
                                || (busWr_ff && busPhase_ff != 3'h0))}};
        end
        else
        begin
            pad1.dataOut     = outLatch_ff[1];
            pad1.outEnable_n = {8{~p01Mode_ff[`QPIO_P01_P1_OUT]}};
        end
    end

    // port two pads: per-bit direction, optional open drain
    always_comb
    begin
        pad2.dataOut = outLatch_ff[2];
        if (p3Mode_ff[`QPIO_P3_OPENDR])
            pad2.outEnable_n = p2Dir_ff | outLatch_ff[2];
        else
            pad2.outEnable_n = p2Dir_ff;
    end

    // port three: 0-3 never driven, 4-7 always driven
    always_comb
    begin
        qpio_pkg::qpio_tout_type toutSel;
        toutSel = qpio_pkg::qpio_tout_type'(p3Mode_ff[7:6]);
        pad3.outEnable_n = 8'h0F;
        pad3.dataOut     = {outLatch_ff[3][7:4], 4'h0};
        // line 4: valid/ready for port 1, bus request, or select
        if (p3Mode_ff[`QPIO_P3_DSEL] && busPhase_ff != 3'h0)
            pad3.dataOut[4] = ~busDsel_ff;
        else if (p3Mode_ff[`QPIO_P3_BUSREQ])
            pad3.dataOut[4] = ~(memReq.start && isExternal(memReq.addr));
        else if (hsEn[1])
            pad3.dataOut[4] = hsIsOut[1] ? (hsState_ff[1] == qpio_pkg::QPIO_HS_IDLE)
                                         : (hsState_ff[1] == qpio_pkg::QPIO_HS_IDLE);
        // line 5: port 0 ready or valid
        if (hsEn[0])
            pad3.dataOut[5] = (hsState_ff[0] == qpio_pkg::QPIO_HS_IDLE);
        // line 6: timer output or port 2 handshake
        if (toutSel == qpio_pkg::QPIO_TOUT_T0)
            pad3.dataOut[6] = timer0Out;
        else if (toutSel == qpio_pkg::QPIO_TOUT_T1)
            pad3.dataOut[6] = timer1Out;
        else if (toutSel == qpio_pkg::QPIO_TOUT_CLK)
            pad3.dataOut[6] = clockEnable;
        else if (hsEn[2])
            pad3.dataOut[6] = (hsState_ff[2] == qpio_pkg::QPIO_HS_IDLE);
        // line 7: serial transmit
        if (p3Mode_ff[`QPIO_P3_SERIAL])
            pad3.dataOut[7] = serialTx;
    end

    // strobes and inputs from port three
    assign address_strobe_n = ~(busPhase_ff == 3'h1);
    assign data_strobe_n    = ~(busPhase_ff == 3'h2 || busPhase_ff == 3'h3);
    assign readWrite        = ~(busWr_ff && busPhase_ff != 3'h0);
    assign strobeEnable_n   = busFloat;
    assign external_interrupt_lines = padSync_ff[27:24];
    assign serialRx   = p3Mode_ff[`QPIO_P3_SERIAL] ? padSync_ff[24] : 1'b1;
    assign busGranted = p3Mode_ff[`QPIO_P3_BUSREQ] && !padSync_ff[27];

    // a bus cycle never starts below the internal limit
    property p_extonly;
        @(posedge clock) disable iff (reset)
        (busPhase_ff == 3'h0 && nxt_busPhase == 3'h1 && clockEnable) |-> isExternal(memReq.addr);
    endproperty
    a_extonly: assert property (p_extonly) else $error("bus cycle for internal address");

    // port three low half never driven
    property p_p3dir;
        @(posedge clock) disable iff (reset) pad3.outEnable_n == 8'h0F;
    endproperty
    a_p3dir: assert property (p_p3dir) else $error("port three direction broken");

    // float mode releases the strobes
    property p_float;
        @(posedge clock) disable iff (reset)
        busFloat |-> strobeEnable_n && (!p1Addr || pad1.outEnable_n == 8'hFF)
                     && (!p0LoAddr || pad0.outEnable_n[3:0] == 4'hF);
    endproperty
    a_float: assert property (p_float) else $error("bus not floated");

    // strobe order: address strobe then data strobe two cycles
    sequence s_addr;
        !address_strobe_n;
    endsequence
    property p_order;
        @(posedge clock) disable iff (reset || !clockEnable)
        s_addr |=> !data_strobe_n [*2];
    endproperty
    a_order: assert property (p_order) else $error("strobe order wrong");

    // one reset cycle leaves modes cleared
    property p_reset;
        @(posedge clock) $past(reset) |-> p01Mode_ff == 8'h00 && p3Mode_ff == 9'h000;
    endproperty
    a_reset: assert property (p_reset) else $error("reset mode wrong");

    // address nibble carries A8-A11
    property p_hiaddr;
        @(posedge clock) disable iff (reset) p0LoAddr |-> pad0.dataOut[3:0] == busAddr_ff[11:8];
    endproperty
    a_hiaddr: assert property (p_hiaddr) else $error("port zero address wrong");

    // handshake done state returns idle after lines idle
    property p_hsdone;
        @(posedge clock) disable iff (reset || !clockEnable)
        (hsState_ff[0] == qpio_pkg::QPIO_HS_DONE && hsEn[0] && !hsIsOut[0] && hsValidIn[2])
        |=> hsState_ff[0] == qpio_pkg::QPIO_HS_IDLE;
    endproperty
    a_hsdone: assert property (p_hsdone) else $error("handshake stuck");

    // open drain never drives a one
    property p_opendr;
        @(posedge clock) disable iff (reset)
        p3Mode_ff[`QPIO_P3_OPENDR] |-> (pad2.outEnable_n | ~pad2.dataOut) == 8'hFF;
    endproperty
    a_opendr: assert property (p_opendr) else $error("open drain drove high");

endmodule // qpio_ports
`default_nettype wire

// file: bench/qpio_ext_mem.sv
/*
  external memory model on the port one / port zero bus.
  assumes low-active strobes, read data wanted while data strobe is low.
*/
`default_nettype none
module qpio_ext_mem
(
    // clock
    input  wire logic                   clock,
    // bus from the device
    input  wire logic                   address_strobe_n,
    input  wire logic                   data_strobe_n,
    input  wire logic                   readWrite,
    input  wire qpio_pkg::qpio_pad_type pad0,
    input  wire qpio_pkg::qpio_pad_type pad1,
    // data back on port one, last written byte
    output logic      [7:0]             busIn,
    output logic      [7:0]             lastWrite
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] addrLatch = 16'h0000;
    logic [7:0]  lastOut   = 8'h00;
    // latch address under the strobe, take write data under data strobe
    always @(posedge clock)
    begin
        if (!address_strobe_n) addrLatch <= {pad0.dataOut, pad1.dataOut};
        if (!data_strobe_n && !readWrite) lastWrite <= pad1.dataOut;
        lastOut <= busIn;
    end
    // released bus toggles every cycle so stale data cannot pass
    assign busIn = (!data_strobe_n && readWrite) ? (addrLatch[7:0] ^ 8'h5A) : ~lastOut;
endmodule // qpio_ext_mem
`default_nettype wire

// file: bench/qpio_ports_tb.sv
/*
  self-checking bench for the quad port block: apb tasks, memory cycles.
  assumes qpio_ext_mem answers reads on port one.
*/
`include "qpio_defines.svh"
`default_nettype none
module qpio_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset, clockEnable, psel, penable, pwrite, pready, pslverr, memDone, serialRx;
    logic busGranted;
    logic address_strobe_n, data_strobe_n, readWrite, strobeEnable_n, serialTx;
    logic timer0Out, timer1Out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, padIn, rd;
    logic [7:0]  memRdata, p0In, p2In, p3In, busIn, lastWrite;
    logic [3:0]  external_interrupt_lines;
    qpio_pkg::qpio_pad_type pad0, pad1, pad2, pad3;
    qpio_pkg::qpio_mem_type memReq;
    int n_errors = 0, num_checks = 0, cycles = 0, k;
    // pins: port one from the memory model, the rest from the bench
    assign padIn = {p3In, p2In, busIn, p0In};
    qpio_ports uut (.clock, .reset, .clockEnable, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .padIn, .pad0, .pad1, .pad2, .pad3,
        .address_strobe_n, .data_strobe_n, .readWrite, .strobeEnable_n, .serialTx,
        .timer0Out, .timer1Out, .memReq, .memDone, .memRdata, .external_interrupt_lines,
        .serialRx, .busGranted);
    qpio_ext_mem mem (.clock, .address_strobe_n, .data_strobe_n, .readWrite, .pad0, .pad1,
        .busIn, .lastWrite);
    // clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            results();
        end
    end
    task results;
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // apb transfer: setup, then access held until pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task waitSync;
        repeat (3) @(negedge clock);
    endtask
    // one external memory cycle with address checks on the pads
    task memCycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                  input logic [7:0] hiExp);
        @(posedge clock);
        memReq <= {1'b1, wr, wr, a, d};
        k = 0;
        do @(negedge clock) k++; while (address_strobe_n !== 1'b0 && k < 20);
        chk("addr low", a[7:0], pad1.dataOut);
        chk("addr high", hiExp, pad0.dataOut);
        chk("direction", !wr, readWrite);
        chk("space select", !wr, pad3.dataOut[4]);
        @(posedge clock);
        memReq.start <= 1'b0;
        k = 0;
        do @(negedge clock) k++; while (memDone !== 1'b1 && k < 20);
        chk("done", 1, memDone);
    endtask
    // main sequence
    initial
    begin
        {reset, psel, penable, pwrite, paddr, pwdata, memReq} = '0;
        reset = 1'b1;
        clockEnable = 1'b1;
        {p0In, p2In, p3In, serialTx, timer0Out, timer1Out} = {24'h0000FF, 3'b100};
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        chk("pad0 oe", 8'hFF, pad0.outEnable_n);
        chk("pad1 oe", 8'hFF, pad1.outEnable_n);
        chk("pad3 oe", 8'h0F, pad3.outEnable_n);
        apb(0, `QPIO_OFF_P2DIR, 0); chk("p2dir", `QPIO_RST_P2DIR, rd);
        apb(0, `QPIO_OFF_P01MODE, 0); chk("p01mode", `QPIO_RST_P01MODE, rd);
        apb(0, `QPIO_OFF_P3MODE, 0); chk("p3mode", `QPIO_RST_P3MODE, rd);
        apb(1, 12'h0FC, 32'hFF); apb(0, 12'h0FC, 0); chk("unmapped", 0, rd);
        apb(1, `QPIO_OFF_P2DIR, 32'h0F); apb(1, `QPIO_OFF_P2DATA, 32'hA5); @(negedge clock);
        chk("pad2 oe", 8'h0F, pad2.outEnable_n);
        chk("pad2 out", 4'hA, pad2.dataOut[7:4]);
        apb(1, `QPIO_OFF_P01MODE, 32'h20); apb(1, `QPIO_OFF_P1DATA, 32'h3C); @(negedge clock);
        chk("pad1 io", 16'h3C00, pad1);
        apb(1, `QPIO_OFF_P01MODE, 32'h19); apb(1, `QPIO_OFF_P0DATA, 32'hB0); @(negedge clock);
        chk("pad0 upper io", 8'hB0, {pad0.dataOut[7:4], pad0.outEnable_n[7:4]});
        apb(1, `QPIO_OFF_P3MODE, 32'h20);
        memCycle(0, 16'h0834, 8'h00, 8'hB8); chk("read data", 8'h6E, memRdata);
        apb(1, `QPIO_OFF_P01MODE, 32'h13);
        memCycle(0, 16'hC3A1, 8'h00, 8'hC3); chk("read data", 8'hFB, memRdata);
        memCycle(1, 16'h0900, 8'h6E, 8'h09); chk("write data", 8'h6E, lastWrite);
        @(posedge clock) memReq <= {1'b1, 1'b0, 1'b0, 16'h07FF, 8'h00};
        k = 0;
        repeat (8) @(negedge clock) k += (memDone === 1'b1);
        chk("internal ignored", 0, k);
        @(posedge clock) memReq.start <= 1'b0;
        apb(1, `QPIO_OFF_P01MODE, 32'h53); @(negedge clock);
        chk("float", 17'h1FFFF, {strobeEnable_n, pad1.outEnable_n, pad0.outEnable_n});
        apb(1, `QPIO_OFF_P3MODE, 32'h48);
        p3In <= 8'hF0; serialTx <= 1'b0; timer0Out <= 1'b1; waitSync;
        chk("serial in", 0, serialRx);
        chk("serial and timer out", 2'b01, pad3.dataOut[7:6]);
        p3In <= 8'h05; waitSync; chk("irq lines", 4'h5, external_interrupt_lines);
        apb(1, `QPIO_OFF_P3MODE, 32'h90); waitSync;
        chk("timer one out", 0, pad3.dataOut[6]);
        chk("granted", 1, busGranted);
        @(posedge clock) memReq <= {1'b1, 1'b0, 1'b0, 16'h0900, 8'h00};
        @(negedge clock);
        chk("bus request", 0, pad3.dataOut[4]);
        @(posedge clock) memReq.start <= 1'b0;
        p3In <= 8'h0D; waitSync; chk("not granted", 0, busGranted);
        // port zero input handshake with open drain on port two
        apb(1, `QPIO_OFF_P01MODE, 0);
        p0In <= 8'h96;
        apb(1, `QPIO_OFF_P3MODE, 32'h101);
        @(negedge clock);
        chk("pad2 open drain", 8'hAF, pad2.outEnable_n);
        @(posedge clock) p3In <= 8'h09;
        waitSync;
        apb(0, `QPIO_OFF_PINS, 0);
        chk("port0 capture", 8'h96, rd[15:8]);
        @(negedge clock);
        chk("port0 ready low", 0, pad3.dataOut[5]);
        @(posedge clock) p3In <= 8'h0D;
        waitSync;
        @(negedge clock);
        chk("port0 ready back", 1, pad3.dataOut[5]);
        // clock enable low freezes register writes
        @(posedge clock) clockEnable <= 1'b0;
        apb(1, `QPIO_OFF_P2DIR, 32'h33);
        clockEnable <= 1'b1;
        apb(0, `QPIO_OFF_P2DIR, 0);
        chk("frozen write", 8'h0F, rd);
        results();
    end
endmodule // qpio_ports_tb
`default_nettype wire
